// ===== bench/drive_engine_model.sv
// stand-in for the drive engine behind the command decoder
// assumes one exec_start_reg pulse per command; results are sampled on exec_done
`timescale 1ns/1ns
module drive_engine_model #(
  parameter int DELAY = 4
) (
  input  wire logic                                clock,
  input  wire logic                                rst_n,
  input  wire logic                                exec_start_reg,
  output logic                                     exec_done,
  output floppy_command_decoder_pkg::exec_result_t exec_result
);
  // three status bytes, then the ID found on the medium
  localparam logic [55:0] GOOD = 56'hC0_01_02_21_22_23_24;
  int cnt;
  // outside the done pulse the lines show the inverse, so stale sampling shows up
  assign exec_result = exec_done ? GOOD : ~GOOD;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      exec_done <= 1'b0;
    end else begin
      exec_done <= (cnt == 1);
      if (exec_start_reg) begin
        cnt <= DELAY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// ===== bench/tb_top.sv
// self-checking bench of the floppy command decoder
// assumes the decoder on its strobe port and the engine model on its far side
`timescale 1ns/1ns
module tb_top;
  logic                                      clock = 0;
  logic                                      rst_n = 0;
  logic                                      address = 0;
  logic [7:0]                                wdata = 8'h00;
  logic                                      wr_en = 0;
  logic                                      rd_en = 0;
  logic [7:0]                                rdata_reg;
  logic                                      exec_start_reg;
  logic                                      exec_done;
  logic                                      standby_reg;
  logic                                      soft_reset_reg;
  floppy_command_decoder_pkg::exec_request_t req;
  floppy_command_decoder_pkg::exec_result_t  exec_result;
  floppy_command_decoder_pkg::timing_t       timing_reg;
  logic [7:0]                                interrupt_status = 8'h61;
  logic [7:0]                                present_cylinder = 8'h2A;
  logic [4:0]                                drive_signals = 5'h15;
  logic [7:0]                                exp_res [7];
  logic [7:0]                                v;
  logic [7:0] disk_op [8] = '{8'h46, 8'h4C, 8'h45, 8'h49, 8'h51, 8'h59, 8'h5D, 8'h42};
  int                                        error_cnt = 0;
  int                                        n_tests = 0;
  int                                        cycles = 0;
  int                                        resets_seen = 0;

  always #5 clock = ~clock;

  floppy_command_decoder DUT (.clock, .rst_n, .address, .wdata, .wr_en, .rd_en, .rdata_reg,
    .exec_request_reg(req), .exec_start_reg, .exec_done, .exec_result, .interrupt_status,
    .present_cylinder, .drive_signals, .timing_reg, .standby_reg, .soft_reset_reg);
  drive_engine_model #(.DELAY(4)) engine (.clock, .rst_n, .exec_start_reg, .exec_done,
    .exec_result);

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic a, output logic [7:0] d);
    @(posedge clock);
    address <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rdata_reg;
  endtask

  // opcode, np parameter bytes 24h upward, poll until no longer executing, check nr results
  task automatic cmd(input logic [7:0] op, input int np, input int nr);
    int n;
    wr(1'h1, op);
    for (int k = 0; k < np; k++)
      wr(1'h1, 8'h24 + 8'(k));
    n = 0;
    v = 8'h00;
    while (v[7] !== 1'b1 && n < 40) begin
      rd(1'h0, v);
      n++;
    end
    chk(v[7], 1'b1);
    for (int k = 0; k < nr; k++) begin
      rd(1'h1, v);
      chk(v, exp_res[k]);
    end
  endtask

  always @(posedge clock) begin
    cycles++;
    if (soft_reset_reg === 1'b1)
      resets_seen++;
    if (cycles == 5000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd(1'h0, v);
    chk(v, 8'h80);
    exp_res = '{8'hC0, 8'h01, 8'h02, 8'h21, 8'h22, 8'h23, 8'h24};
    for (int i = 0; i < 8; i++) begin
      cmd(disk_op[i], 8, 7);
      chk(req.command, 16'(i));
      chk({req.param_bytes[4], 7'h0, req.double_density_select}, 16'h2801);
    end
    cmd(8'hA6, 8, 7);
    v = {5'h0, req.multitrack_select, req.double_density_select, req.skip_deleted_option};
    chk(v, 8'h05);
    cmd(8'h4A, 1, 7);
    chk(req.command, floppy_command_decoder_pkg::CMD_READ_ID);
    cmd(8'h4D, 5, 7);
    chk(req.param_bytes[4], 8'h28);
    cmd(8'h07, 1, 0);
    chk(req.param_bytes[0], 8'h20);
    cmd(8'h0F, 2, 0);
    chk(req.param_bytes[1], 8'h25);
    exp_res[0] = 8'h61;
    exp_res[1] = 8'h2A;
    cmd(8'h08, 0, 2);
    exp_res[0] = 8'hAC;
    cmd(8'h04, 1, 1);
    cmd(8'h03, 2, 0);
    chk(timing_reg, 16'h2425);
    // an opcode sent while a result is pending must be dropped
    wr(1'h1, 8'hE5);
    wr(1'h1, 8'h08);
    rd(1'h0, v);
    chk(v, 8'hD0);
    rd(1'h1, v);
    chk(v, 8'h80);
    rd(1'h0, v);
    chk(v, 8'h80);
    rd(1'h1, v);
    chk(v, 8'h00);
    wr(1'h1, 8'h35);
    wr(1'h1, 8'h08);
    rd(1'h0, v);
    chk({v, 7'h0, standby_reg}, 16'h0001);
    wr(1'h1, 8'h34);
    rd(1'h0, v);
    chk({v, 7'h0, standby_reg}, 16'h8000);
    wr(1'h1, 8'h36);
    rd(1'h0, v);
    chk(v, 8'h80);
    chk(timing_reg, 16'h0000);
    chk(16'(resets_seen), 16'h0001);
    conclude();
  end
endmodule

// ===== include/floppy_command_decoder_consts.svh
// offsets, field positions, counts and fixed values of the command decoder
// assumes inclusion by the package and the decoder module only
`ifndef FLOPPY_COMMAND_DECODER_CONSTS_SVH
`define FLOPPY_COMMAND_DECODER_CONSTS_SVH

`define ADDR_MAIN_STATUS 1'h0
`define ADDR_DATA        1'h1
`define MSR_REQUEST_BIT  7
`define MSR_TO_HOST_BIT  6
`define MSR_EXEC_BIT     5
`define MSR_BUSY_BIT     4
`define PARAM_SLOTS      8
`define RESULT_SLOTS     7
`define N_PARAMS_DISK    4'h8
`define N_PARAMS_FORMAT  4'h5
`define N_PARAMS_SEEK    4'h2
`define N_PARAMS_DRIVE   4'h1
`define N_RESULTS_DISK   3'h7
`define N_RESULTS_SENSE  3'h2
`define N_RESULTS_ONE    3'h1
`define INVALID_ST0      8'h80
`define OPC_RECALIBRATE  8'h07
`define OPC_SENSE_INT    8'h08
`define OPC_SENSE_DRIVE  8'h04
`define OPC_SEEK         8'h0F
`define OPC_SPECIFY      8'h03
`define OPC_STANDBY      8'h35
`define OPC_LEAVE_STBY   8'h34
`define OPC_SOFT_RESET   8'h36
`define LOW_READ         5'h06
`define LOW_READ_DEL     5'h0C
`define LOW_WRITE        5'h05
`define LOW_WRITE_DEL    5'h09
`define LOW_SCAN_EQ      5'h11
`define LOW_SCAN_LE      5'h19
`define LOW_SCAN_HE      5'h1D
`define LOW_READ_TRACK   5'h02
`define LOW_READ_ID      5'h0A
`define LOW_FORMAT       5'h0D

`endif

// ===== include/floppy_command_decoder_pkg.sv
// types of the floppy command decoder
// assumes the constants header is on the include path
package floppy_command_decoder_pkg;
  `include "floppy_command_decoder_consts.svh"

  typedef enum logic [1:0] {
    PH_IDLE   = 2'h0,
    PH_PARAM  = 2'h1,
    PH_EXEC   = 2'h2,
    PH_RESULT = 2'h3
  } phase_t;

  typedef enum logic [4:0] {
    CMD_READ        = 5'h00,
    CMD_READ_DEL    = 5'h01,
    CMD_WRITE       = 5'h02,
    CMD_WRITE_DEL   = 5'h03,
    CMD_SCAN_EQ     = 5'h04,
    CMD_SCAN_LE     = 5'h05,
    CMD_SCAN_HE     = 5'h06,
    CMD_READ_TRACK  = 5'h07,
    CMD_READ_ID     = 5'h08,
    CMD_FORMAT      = 5'h09,
    CMD_RECALIBRATE = 5'h0A,
    CMD_SEEK        = 5'h0B,
    CMD_SENSE_INT   = 5'h0C,
    CMD_SENSE_DRIVE = 5'h0D,
    CMD_SPECIFY     = 5'h0E,
    CMD_STANDBY     = 5'h0F,
    CMD_LEAVE_STBY  = 5'h10,
    CMD_SOFT_RESET  = 5'h11,
    CMD_INVALID     = 5'h12
  } command_t;

  // result bytes in the order handed to the host
  typedef struct packed {
    logic [7:0] status_byte_zero;
    logic [7:0] status_byte_one;
    logic [7:0] status_byte_two;
    logic [7:0] cylinder;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size_code;
  } exec_result_t;

  typedef struct packed {
    command_t   command;
    logic       multitrack_select;
    logic       double_density_select;
    logic       skip_deleted_option;
    logic [`PARAM_SLOTS-1:0][7:0] param_bytes;
  } exec_request_t;

  typedef struct packed {
    logic [3:0] step_rate_time;
    logic [3:0] head_unload_time;
    logic [6:0] head_load_time;
    logic       no_dma_flag;
  } timing_t;

  typedef struct packed {
    phase_t     phase;
    exec_request_t req;
    logic [3:0] param_index;
    logic [3:0] param_count;
    logic [`RESULT_SLOTS-1:0][7:0] results;
    logic [2:0] result_index;
    logic [2:0] result_count;
    logic [7:0] rdata;
    logic       exec_start;
    logic       standby;
    logic       soft_reset;
    timing_t    timing;
  } state_t;
endpackage

// ===== src/floppy_command_decoder.sv
// command and result phase sequencer of a floppy disk controller
// assumes a host on a plain strobe port and a drive engine that runs each execution
`timescale 1ns/1ns
`include "floppy_command_decoder_consts.svh"

module floppy_command_decoder (
  input  wire logic                                    clock,
  input  wire logic                                    rst_n,
  input  wire logic                                    address,
  input  wire logic [7:0]                              wdata,
  input  wire logic                                    wr_en,
  input  wire logic                                    rd_en,
  output logic      [7:0]                              rdata_reg,
  output floppy_command_decoder_pkg::exec_request_t    exec_request_reg,
  output logic                                         exec_start_reg,
  input  wire logic                                    exec_done,
  input  floppy_command_decoder_pkg::exec_result_t     exec_result,
  input  wire logic [7:0]                              interrupt_status,
  input  wire logic [7:0]                              present_cylinder,
  input  wire logic [4:0]                              drive_signals,
  output floppy_command_decoder_pkg::timing_t          timing_reg,
  output logic                                         standby_reg,
  output logic                                         soft_reset_reg
);
  floppy_command_decoder_pkg::state_t s_reg;
  floppy_command_decoder_pkg::state_t s_next;

  function automatic floppy_command_decoder_pkg::command_t decode(input logic [7:0] op);
    logic [4:0] low;
    low = op[4:0];
    decode = floppy_command_decoder_pkg::CMD_INVALID;
    unique case (1'b1)
      (low == `LOW_READ):     decode = floppy_command_decoder_pkg::CMD_READ;
      (low == `LOW_READ_DEL): decode = floppy_command_decoder_pkg::CMD_READ_DEL;
      (low == `LOW_WRITE && !op[5]): decode = floppy_command_decoder_pkg::CMD_WRITE;
      (low == `LOW_WRITE_DEL && !op[5]):
        decode = floppy_command_decoder_pkg::CMD_WRITE_DEL;
      (low == `LOW_SCAN_EQ): decode = floppy_command_decoder_pkg::CMD_SCAN_EQ;
      (low == `LOW_SCAN_LE): decode = floppy_command_decoder_pkg::CMD_SCAN_LE;
      (low == `LOW_SCAN_HE): decode = floppy_command_decoder_pkg::CMD_SCAN_HE;
      (low == `LOW_READ_TRACK && !op[7]):
        decode = floppy_command_decoder_pkg::CMD_READ_TRACK;
      (low == `LOW_READ_ID && !op[7] && !op[5]):
        decode = floppy_command_decoder_pkg::CMD_READ_ID;
      (low == `LOW_FORMAT && !op[7] && !op[5]):
        decode = floppy_command_decoder_pkg::CMD_FORMAT;
      (op == `OPC_RECALIBRATE): decode = floppy_command_decoder_pkg::CMD_RECALIBRATE;
      (op == `OPC_SENSE_INT):   decode = floppy_command_decoder_pkg::CMD_SENSE_INT;
      (op == `OPC_SENSE_DRIVE): decode = floppy_command_decoder_pkg::CMD_SENSE_DRIVE;
      (op == `OPC_SEEK):        decode = floppy_command_decoder_pkg::CMD_SEEK;
      (op == `OPC_SPECIFY):     decode = floppy_command_decoder_pkg::CMD_SPECIFY;
      (op == `OPC_STANDBY):     decode = floppy_command_decoder_pkg::CMD_STANDBY;
      (op == `OPC_LEAVE_STBY):  decode = floppy_command_decoder_pkg::CMD_LEAVE_STBY;
      (op == `OPC_SOFT_RESET):  decode = floppy_command_decoder_pkg::CMD_SOFT_RESET;
      default: ;
    endcase
  endfunction

  function automatic logic [3:0] param_total(input floppy_command_decoder_pkg::command_t c);
    unique case (c)
      floppy_command_decoder_pkg::CMD_FORMAT:  param_total = `N_PARAMS_FORMAT;
      floppy_command_decoder_pkg::CMD_SEEK,
      floppy_command_decoder_pkg::CMD_SPECIFY: param_total = `N_PARAMS_SEEK;
      floppy_command_decoder_pkg::CMD_READ_ID,
      floppy_command_decoder_pkg::CMD_RECALIBRATE,
      floppy_command_decoder_pkg::CMD_SENSE_DRIVE: param_total = `N_PARAMS_DRIVE;
      floppy_command_decoder_pkg::CMD_SENSE_INT,
      floppy_command_decoder_pkg::CMD_STANDBY,
      floppy_command_decoder_pkg::CMD_LEAVE_STBY,
      floppy_command_decoder_pkg::CMD_SOFT_RESET,
      floppy_command_decoder_pkg::CMD_INVALID: param_total = 4'h0;
      default: param_total = `N_PARAMS_DISK;
    endcase
  endfunction

  // commands handed to the drive engine; seek and recalibrate end with no result
  function automatic logic uses_engine(input floppy_command_decoder_pkg::command_t c);
    uses_engine = (c <= floppy_command_decoder_pkg::CMD_SEEK);
  endfunction

  function automatic logic no_result(input floppy_command_decoder_pkg::command_t c);
    no_result = (c == floppy_command_decoder_pkg::CMD_RECALIBRATE) ||
                (c == floppy_command_decoder_pkg::CMD_SEEK);
  endfunction

  logic                                     data_wr;
  logic                                     data_rd;
  logic                                     launch;
  floppy_command_decoder_pkg::command_t     op_cmd;
  floppy_command_decoder_pkg::command_t     run_cmd;
  logic [`PARAM_SLOTS-1:0][7:0]             pbytes;
  logic [7:0]                               main_status;

  assign data_wr = wr_en && (address == `ADDR_DATA);
  assign data_rd = rd_en && (address == `ADDR_DATA);
  assign op_cmd  = decode(wdata);

  always_comb begin
    // standby shows an all-zero main status so the host stays off
    main_status = 8'h00;
    if (!s_reg.standby) begin
      main_status[`MSR_REQUEST_BIT] = (s_reg.phase != floppy_command_decoder_pkg::PH_EXEC);
      main_status[`MSR_TO_HOST_BIT] = (s_reg.phase == floppy_command_decoder_pkg::PH_RESULT);
      main_status[`MSR_EXEC_BIT]    = (s_reg.phase == floppy_command_decoder_pkg::PH_EXEC);
      main_status[`MSR_BUSY_BIT]    = (s_reg.phase != floppy_command_decoder_pkg::PH_IDLE);
    end
  end

  always_comb begin
    s_next            = s_reg;
    s_next.exec_start = 1'b0;
    s_next.soft_reset = 1'b0;
    s_next.rdata      = 8'h00;
    launch            = 1'b0;
    run_cmd           = s_reg.req.command;
    pbytes            = s_reg.req.param_bytes;
    if (data_wr) begin
      unique case (s_reg.phase)
        floppy_command_decoder_pkg::PH_IDLE: begin
          // in standby only the wake and reset opcodes are heard
          if (!s_reg.standby || op_cmd == floppy_command_decoder_pkg::CMD_LEAVE_STBY ||
              op_cmd == floppy_command_decoder_pkg::CMD_SOFT_RESET) begin
            s_next.req.command               = op_cmd;
            s_next.req.multitrack_select     = wdata[7] && (op_cmd <=
                floppy_command_decoder_pkg::CMD_SCAN_HE);
            s_next.req.double_density_select = wdata[6] &&
                uses_engine(op_cmd) && !no_result(op_cmd);
            s_next.req.skip_deleted_option   = wdata[5] && (op_cmd <=
                floppy_command_decoder_pkg::CMD_READ_TRACK);
            s_next.param_index = 4'h0;
            s_next.param_count = param_total(op_cmd);
            run_cmd            = op_cmd;
            if (param_total(op_cmd) == 4'h0) begin
              launch = 1'b1;
            end else begin
              s_next.phase = floppy_command_decoder_pkg::PH_PARAM;
            end
          end
        end
        floppy_command_decoder_pkg::PH_PARAM: begin
          pbytes[s_reg.param_index[2:0]] = wdata;
          s_next.req.param_bytes         = pbytes;
          s_next.param_index             = s_reg.param_index + 4'h1;
          launch = (s_reg.param_index == s_reg.param_count - 4'h1);
        end
        floppy_command_decoder_pkg::PH_EXEC,
        floppy_command_decoder_pkg::PH_RESULT: ; // busy: a byte written now is dropped
      endcase
    end
    if (launch) begin
      s_next.result_index = 3'h0;
      unique case (run_cmd)
        // short answers fill the top slots so every read walks down from the same end
        floppy_command_decoder_pkg::CMD_SENSE_INT: begin
          s_next.results[`RESULT_SLOTS-1] = interrupt_status;
          s_next.results[`RESULT_SLOTS-2] = present_cylinder;
          s_next.result_count  = `N_RESULTS_SENSE;
          s_next.phase         = floppy_command_decoder_pkg::PH_RESULT;
        end
        floppy_command_decoder_pkg::CMD_SENSE_DRIVE: begin
          s_next.results[`RESULT_SLOTS-1] = {drive_signals, pbytes[0][2:0]};
          s_next.result_count  = `N_RESULTS_ONE;
          s_next.phase         = floppy_command_decoder_pkg::PH_RESULT;
        end
        floppy_command_decoder_pkg::CMD_SPECIFY: begin
          s_next.timing.step_rate_time   = pbytes[0][7:4];
          s_next.timing.head_unload_time = pbytes[0][3:0];
          s_next.timing.head_load_time   = pbytes[1][7:1];
          s_next.timing.no_dma_flag      = pbytes[1][0];
          s_next.phase                   = floppy_command_decoder_pkg::PH_IDLE;
        end
        floppy_command_decoder_pkg::CMD_STANDBY: begin
          s_next.standby = 1'b1;
          s_next.phase   = floppy_command_decoder_pkg::PH_IDLE;
        end
        floppy_command_decoder_pkg::CMD_LEAVE_STBY: begin
          s_next.standby = 1'b0;
          s_next.phase   = floppy_command_decoder_pkg::PH_IDLE;
        end
        floppy_command_decoder_pkg::CMD_SOFT_RESET: begin
          s_next            = '0;
          s_next.soft_reset = 1'b1;
        end
        floppy_command_decoder_pkg::CMD_INVALID: begin
          s_next.results[`RESULT_SLOTS-1] = `INVALID_ST0;
          s_next.result_count = `N_RESULTS_ONE;
          s_next.phase        = floppy_command_decoder_pkg::PH_RESULT;
        end
        default: begin
          // recalibrate ignores bit 2 of the drive byte; the decoder clears it before the engine starts
          if (run_cmd == floppy_command_decoder_pkg::CMD_RECALIBRATE) begin
            s_next.req.param_bytes[0][2] = 1'b0;
          end
          s_next.exec_start = 1'b1;
          s_next.phase      = floppy_command_decoder_pkg::PH_EXEC;
        end
      endcase
    end
    if (s_reg.phase == floppy_command_decoder_pkg::PH_EXEC && exec_done) begin
      if (no_result(s_reg.req.command)) begin
        s_next.phase = floppy_command_decoder_pkg::PH_IDLE;
      end else begin
        // format ID bytes are copied as the engine leaves them; meaningless to the host
        s_next.results      = exec_result;
        s_next.result_count = `N_RESULTS_DISK;
        s_next.phase        = floppy_command_decoder_pkg::PH_RESULT;
      end
    end
    if (rd_en && address == `ADDR_MAIN_STATUS) begin
      s_next.rdata = main_status;
    end else if (data_rd && s_reg.phase == floppy_command_decoder_pkg::PH_RESULT) begin
      s_next.rdata        = s_reg.results[`RESULT_SLOTS - 1 - s_reg.result_index];
      s_next.result_index = s_reg.result_index + 3'h1;
      if (s_reg.result_index == s_reg.result_count - 3'h1) begin
        s_next.phase = floppy_command_decoder_pkg::PH_IDLE;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_reg        = s_reg.rdata;
  assign exec_request_reg = s_reg.req;
  assign exec_start_reg   = s_reg.exec_start;
  assign timing_reg       = s_reg.timing;
  assign standby_reg      = s_reg.standby;
  assign soft_reset_reg   = s_reg.soft_reset;

  // helper views for the checks below
  logic [7:0] next_result;
  logic       idle_wr;
  assign next_result = s_reg.results[`RESULT_SLOTS - 1 - s_reg.result_index];
  assign idle_wr     = data_wr && s_reg.phase == floppy_command_decoder_pkg::PH_IDLE &&
                       !s_reg.standby;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_invalid_answer: assert property (
    idle_wr && op_cmd == floppy_command_decoder_pkg::CMD_INVALID |=>
      s_reg.phase == floppy_command_decoder_pkg::PH_RESULT && s_reg.result_count == 3'h1 &&
      next_result == `INVALID_ST0)
    else $error("invalid opcode did not answer 80h");
  chk_result_order: assert property (
    data_rd && s_reg.phase == floppy_command_decoder_pkg::PH_RESULT |=>
      rdata_reg == $past(next_result))
    else $error("result byte out of order");
  chk_busy_lockout: assert property (
    data_wr && s_reg.phase == floppy_command_decoder_pkg::PH_RESULT |=>
      s_reg.req.command == $past(s_reg.req.command) && !exec_start_reg)
    else $error("opcode taken during result phase");
  chk_start_after_last: assert property (
    data_wr && s_reg.phase == floppy_command_decoder_pkg::PH_PARAM &&
    s_reg.param_index == s_reg.param_count - 4'h1 && uses_engine(s_reg.req.command) |=>
      exec_start_reg ##1 !exec_start_reg)
    else $error("execution not started after last parameter");
  chk_seven_results: assert property (
    s_reg.phase == floppy_command_decoder_pkg::PH_EXEC && exec_done &&
    !no_result(s_reg.req.command) |=> s_reg.result_count == 3'h7 &&
      s_reg.results[`RESULT_SLOTS-1] == $past(exec_result.status_byte_zero))
    else $error("disk command result not seven bytes");
  chk_seek_no_result: assert property (
    s_reg.phase == floppy_command_decoder_pkg::PH_EXEC && exec_done &&
    no_result(s_reg.req.command) |=> s_reg.phase == floppy_command_decoder_pkg::PH_IDLE)
    else $error("seek or recalibrate entered a result phase");
  chk_write_bit5: assert property (
    idle_wr && wdata[4:0] == `LOW_WRITE && wdata[5] |=>
      s_reg.req.command == floppy_command_decoder_pkg::CMD_INVALID)
    else $error("write with bit 5 set was accepted");
  chk_track_no_mt: assert property (
    idle_wr && op_cmd == floppy_command_decoder_pkg::CMD_READ_TRACK |=>
      !s_reg.req.multitrack_select && s_reg.param_count == 4'h8)
    else $error("read track took multitrack or wrong length");
  chk_sense_drive: assert property (
    s_reg.phase == floppy_command_decoder_pkg::PH_PARAM && data_wr &&
    s_reg.req.command == floppy_command_decoder_pkg::CMD_SENSE_DRIVE |=>
      s_reg.result_count == 3'h1 && next_result[2:0] == $past(wdata[2:0]))
    else $error("sense drive status result wrong");
  chk_specify_store: assert property (
    data_wr && s_reg.phase == floppy_command_decoder_pkg::PH_PARAM &&
    s_reg.req.command == floppy_command_decoder_pkg::CMD_SPECIFY &&
    s_reg.param_index == 4'h1 |=>
      timing_reg == {$past(s_reg.req.param_bytes[0]), $past(wdata)})
    else $error("specify values not stored");
  chk_sense_int_bytes: assert property (
    idle_wr && op_cmd == floppy_command_decoder_pkg::CMD_SENSE_INT |=>
      s_reg.result_count == 3'h2 && next_result == $past(interrupt_status) &&
      s_reg.results[`RESULT_SLOTS-2] == $past(present_cylinder))
    else $error("sense interrupt bytes wrong");
  chk_standby_deaf: assert property (
    data_wr && s_reg.phase == floppy_command_decoder_pkg::PH_IDLE && s_reg.standby &&
    op_cmd == floppy_command_decoder_pkg::CMD_SENSE_INT |=>
      s_reg.phase == floppy_command_decoder_pkg::PH_IDLE && standby_reg)
    else $error("opcode taken in standby");
  chk_mt_gated: assert property (
    idle_wr && op_cmd > floppy_command_decoder_pkg::CMD_SCAN_HE |=>
      !s_reg.req.multitrack_select)
    else $error("multitrack kept on a command without it");
  chk_read_id_short: assert property (
    idle_wr && op_cmd == floppy_command_decoder_pkg::CMD_READ_ID |=>
      s_reg.phase == floppy_command_decoder_pkg::PH_PARAM && s_reg.param_count == 4'h1)
    else $error("read id parameter count wrong");
  chk_soft_reset: assert property (
    data_wr && s_reg.phase == floppy_command_decoder_pkg::PH_IDLE &&
    op_cmd == floppy_command_decoder_pkg::CMD_SOFT_RESET |=>
      soft_reset_reg && !standby_reg && s_reg.timing == '0)
    else $error("software reset did not clear state");

  cov_read_command: cover property (
    idle_wr && op_cmd == floppy_command_decoder_pkg::CMD_READ ##[1:20] exec_start_reg);
  cov_result_done: cover property (
    s_reg.phase == floppy_command_decoder_pkg::PH_RESULT && s_reg.result_count == 3'h7 ##[1:40]
    s_reg.phase == floppy_command_decoder_pkg::PH_IDLE);
  cov_standby_cycle: cover property (standby_reg ##[1:20] !standby_reg);
  cov_sense_int: cover property (
    idle_wr && op_cmd == floppy_command_decoder_pkg::CMD_SENSE_INT ##[1:10] data_rd);
endmodule
